// ===== include/pwm_on_off_counter_defines.svh
// offsets, field positions, reset values and the config write mask
`ifndef PWM_ON_OFF_COUNTER_DEFINES_SVH
`define PWM_ON_OFF_COUNTER_DEFINES_SVH
`define ON_TIME_OFS 4'h0
`define OFF_TIME_OFS 4'h4
`define CONFIG_OFS 4'h8
`define ON_TIME_RST 16'h0000
`define OFF_TIME_RST 16'hffff
`define CONFIG_RST 16'h0000
`define CFG_ENABLE_BIT 0
`define CFG_CLKSEL_BIT 1
`define CFG_INVERT_BIT 2
`define CFG_PREDIV_LSB 3
`define CFG_PREDIV_MSB 6
`define CFG_WRITE_MASK 16'h007f
`endif

// ===== include/pwm_on_off_counter_pkg.sv
// types for the pwm channel
package pwm_on_off_counter_pkg;
    typedef enum logic [1:0] {
        PHASE_OFF = 2'b01,
        PHASE_ON = 2'b10
    } phase_t;
    typedef struct packed {
        logic [3:0] prediv;
        logic invert;
        logic clk_sel;
        logic enable;
    } config_t;
endpackage

// ===== core/pwm_on_off_counter.sv
// single pwm channel with on/off down-counter and holding registers
`include "pwm_on_off_counter_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pwm_on_off_counter #(
    parameter int COUNT_W = 16
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic SLOW_CLOCK_TICK,
    input wire logic SLEEP_REQUEST,
    input wire logic [3:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [1:0] BYTE_EN,
    input wire logic [15:0] WR_DATA,
    output logic [15:0] RD_DATA,
    output logic PWM_OUT,
    output logic CLOCK_REQUEST
);
    logic [COUNT_W-1:0] on_count_reg;
    logic [COUNT_W-1:0] off_count_reg;
    logic [COUNT_W-1:0] on_hold_reg;
    logic [COUNT_W-1:0] off_hold_reg;
    logic [3:0] hold_bytes_reg;
    logic [3:0] hold_bytes_next;
    pwm_on_off_counter_pkg::config_t cfg_reg;
    pwm_on_off_counter_pkg::phase_t phase_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [3:0] div_reg;
    logic [15:0] rd_data_reg;
    logic pwm_out_reg;
    logic wr_on;
    logic wr_off;
    logic wr_cfg;
    logic src_tick;
    logic tick;
    logic run;
    logic full_on;
    logic full_off;
    logic hold_full;
    logic off_done;
    logic transfer;
    logic on_level;

    assign wr_on = WR_EN && (ADDR == `ON_TIME_OFS);
    assign wr_off = WR_EN && (ADDR == `OFF_TIME_OFS);
    assign wr_cfg = WR_EN && (ADDR == `CONFIG_OFS);
    assign run = cfg_reg.enable && !SLEEP_REQUEST;
    assign full_on = (off_count_reg == '0);
    assign full_off = !full_on && (on_count_reg == '0);

    // byte-complete tracking of the holding pair
    always_comb begin
        hold_bytes_next = hold_bytes_reg;
        if (wr_on) begin
            hold_bytes_next[1:0] = hold_bytes_reg[1:0] | BYTE_EN;
        end
        if (wr_off) begin
            hold_bytes_next[3:2] = hold_bytes_reg[3:2] | BYTE_EN;
        end
    end
    assign hold_full = (hold_bytes_reg == 4'hf);

    // source select and pre-divider
    assign src_tick = cfg_reg.clk_sel ? SLOW_CLOCK_TICK : 1'b1;
    assign tick = run && src_tick && (div_reg == cfg_reg.prediv);

    assign off_done = tick && (phase_reg == pwm_on_off_counter_pkg::PHASE_OFF)
        && (count_reg == '0);
    assign transfer = hold_full && (full_on || off_done || !run);

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_reg <= 4'h0;
        end else if (CLK_EN) begin
            if (!run) begin
                div_reg <= 4'h0;
            end else if (src_tick) begin
                if (div_reg == cfg_reg.prediv) begin
                    div_reg <= 4'h0;
                end else begin
                    div_reg <= div_reg + 4'h1;
                end
            end
        end
    end

    // holding registers
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            on_hold_reg <= '0;
            off_hold_reg <= '0;
            hold_bytes_reg <= 4'h0;
        end else if (CLK_EN) begin
            if (wr_on && BYTE_EN[0]) begin
                on_hold_reg[7:0] <= WR_DATA[7:0];
            end
            if (wr_on && BYTE_EN[1]) begin
                on_hold_reg[15:8] <= WR_DATA[15:8];
            end
            if (wr_off && BYTE_EN[0]) begin
                off_hold_reg[7:0] <= WR_DATA[7:0];
            end
            if (wr_off && BYTE_EN[1]) begin
                off_hold_reg[15:8] <= WR_DATA[15:8];
            end
            if (transfer) begin
                hold_bytes_reg <= 4'h0;
            end else begin
                hold_bytes_reg <= hold_bytes_next;
            end
        end
    end

    // active count registers
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            on_count_reg <= `ON_TIME_RST;
            off_count_reg <= `OFF_TIME_RST;
        end else if (CLK_EN) begin
            if (transfer) begin
                on_count_reg <= on_hold_reg;
                off_count_reg <= off_hold_reg;
            end
        end
    end

    // configuration
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_reg <= pwm_on_off_counter_pkg::config_t'(7'(`CONFIG_RST));
        end else if (CLK_EN) begin
            if (wr_cfg && BYTE_EN[0]) begin
                cfg_reg.enable <= WR_DATA[`CFG_ENABLE_BIT];
                cfg_reg.clk_sel <= WR_DATA[`CFG_CLKSEL_BIT];
                cfg_reg.invert <= WR_DATA[`CFG_INVERT_BIT];
                cfg_reg.prediv <= WR_DATA[`CFG_PREDIV_MSB:`CFG_PREDIV_LSB];
            end
        end
    end

    // phase state machine and down-counter
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            phase_reg <= pwm_on_off_counter_pkg::PHASE_OFF;
            count_reg <= '0;
        end else if (CLK_EN) begin
            if (!run) begin
                phase_reg <= pwm_on_off_counter_pkg::PHASE_OFF;
                count_reg <= '0;
            end else if (tick) begin
                case (phase_reg)
                    pwm_on_off_counter_pkg::PHASE_OFF: begin
                        if (count_reg != '0) begin
                            count_reg <= count_reg - 1'b1;
                        end else if (full_on) begin
                            phase_reg <= pwm_on_off_counter_pkg::PHASE_ON;
                        end else if (!full_off) begin
                            phase_reg <= pwm_on_off_counter_pkg::PHASE_ON;
                            count_reg <= on_count_reg;
                        end
                    end
                    pwm_on_off_counter_pkg::PHASE_ON: begin
                        if (full_on) begin
                            count_reg <= '0;
                        end else if (count_reg != '0) begin
                            count_reg <= count_reg - 1'b1;
                        end else begin
                            phase_reg <= pwm_on_off_counter_pkg::PHASE_OFF;
                            count_reg <= off_count_reg;
                        end
                    end
                    default: begin
                        phase_reg <= pwm_on_off_counter_pkg::PHASE_OFF;
                        count_reg <= '0;
                    end
                endcase
            end
        end
    end

    // output level, polarity applied
    assign on_level = run && (phase_reg == pwm_on_off_counter_pkg::PHASE_ON);
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pwm_out_reg <= 1'b0;
        end else if (CLK_EN) begin
            pwm_out_reg <= on_level ^ cfg_reg.invert;
        end
    end
    assign PWM_OUT = pwm_out_reg;

    // read data
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_data_reg <= 16'h0000;
        end else if (CLK_EN) begin
            if (RD_EN && (ADDR == `ON_TIME_OFS)) begin
                rd_data_reg <= on_count_reg;
            end else if (RD_EN && (ADDR == `OFF_TIME_OFS)) begin
                rd_data_reg <= off_count_reg;
            end else if (RD_EN && (ADDR == `CONFIG_OFS)) begin
                rd_data_reg <= 16'(cfg_reg) & `CFG_WRITE_MASK;
            end else if (RD_EN) begin
                rd_data_reg <= 16'h0000;
            end
        end
    end
    assign RD_DATA = rd_data_reg;

    assign CLOCK_REQUEST = cfg_reg.enable && !SLEEP_REQUEST;
endmodule
`default_nettype wire

// ===== tb/pwm_on_off_counter_monitor.sv
// port checker for the pwm channel
`timescale 1ns/1ps
`default_nettype none
module pwm_on_off_counter_monitor #(
    parameter int COUNT_W = 16
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic SLOW_CLOCK_TICK,
    input wire logic SLEEP_REQUEST,
    input wire logic [3:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [1:0] BYTE_EN,
    input wire logic [15:0] WR_DATA,
    input wire logic [15:0] RD_DATA,
    input wire logic PWM_OUT,
    input wire logic CLOCK_REQUEST
);
    logic [6:0] cfg_reg;
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_reg <= 7'h00;
        end else if (CLK_EN && WR_EN && ADDR == 4'h8 && BYTE_EN[0]) begin
            cfg_reg <= WR_DATA[6:0];
        end
    end
    sequence idle_s;
        (!cfg_reg[0] && CLK_EN && $stable(cfg_reg))[*3];
    endsequence
    sequence asleep_s;
        (SLEEP_REQUEST && CLK_EN && $stable(cfg_reg))[*3];
    endsequence
    sequence slow_s;
        (cfg_reg[1:0] == 2'h3 && !SLEEP_REQUEST && $stable(cfg_reg))[*3];
    endsequence
    clock_request_a: assert property (
        CLOCK_REQUEST == (cfg_reg[0] && !SLEEP_REQUEST)
    ) else $error("bad clock request");
    idle_out_a: assert property (
        idle_s |-> PWM_OUT == cfg_reg[2]
    ) else $error("bad idle level");
    sleep_out_a: assert property (
        asleep_s |-> PWM_OUT == cfg_reg[2]
    ) else $error("bad sleep level");
    config_read_a: assert property (
        RD_EN && CLK_EN && ADDR == 4'h8 |=> RD_DATA == {9'h000, $past(cfg_reg)}
    ) else $error("bad config read");
    slow_tick_a: assert property (
        slow_s ##0 !$past(SLOW_CLOCK_TICK, 2) |-> $stable(PWM_OUT)
    ) else $error("edge without tick");
    invert_flip_a: assert property (
        cfg_reg[1:0] == 2'h3 && $stable(cfg_reg[1:0]) && CLK_EN &&
        !SLEEP_REQUEST && $changed(cfg_reg[2]) && !$past(SLOW_CLOCK_TICK)
        |=> PWM_OUT != $past(PWM_OUT)
    ) else $error("invert ignored");
    freeze_a: assert property (
        !CLK_EN |=> $stable(PWM_OUT) && $stable(RD_DATA)
    ) else $error("moved while frozen");
    unmapped_read_a: assert property (
        RD_EN && CLK_EN && ADDR != 4'h0 && ADDR != 4'h4 && ADDR != 4'h8
        |=> RD_DATA == 16'h0000
    ) else $error("bad unmapped read");
endmodule
bind pwm_on_off_counter pwm_on_off_counter_monitor #(.COUNT_W(COUNT_W))
    u_mon (.*);
`default_nettype wire

// ===== tb/pwm_load_model.sv
// load model timing the high and low runs of the pulse pin
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    input wire logic CLOCK,
    input wire logic PWM_OUT,
    output logic [15:0] hi_len,
    output logic [15:0] lo_len
);
    logic last_reg;
    logic [15:0] run_reg;
    always_ff @(posedge CLOCK) begin
        last_reg <= PWM_OUT;
        run_reg <= (PWM_OUT != last_reg) ? 16'h0001 : run_reg + 16'h0001;
        if (PWM_OUT != last_reg && last_reg) hi_len <= run_reg;
        if (PWM_OUT != last_reg && !last_reg) lo_len <= run_reg;
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// register-level tests of the pwm channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic CLOCK = 1'b0, RESET_N = 1'b0, CLK_EN = 1'b1, TICK = 1'b0;
    logic SLEEP = 1'b0, WR_EN = 1'b0, RD_EN = 1'b0, PWM_OUT, CLOCK_REQUEST;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WR_DATA = 16'h0000, RD_DATA, hi_len, lo_len;
    int err_total = 0, total_checks = 0, cyc = 0, tdiv = 0;
    pwm_on_off_counter u_pwm_on_off_counter (.CLOCK(CLOCK),
        .RESET_N(RESET_N), .CLK_EN(CLK_EN), .SLOW_CLOCK_TICK(TICK),
        .SLEEP_REQUEST(SLEEP), .ADDR(ADDR), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .BYTE_EN(2'h3), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
        .PWM_OUT(PWM_OUT), .CLOCK_REQUEST(CLOCK_REQUEST));
    pwm_load_model u_pwm_load_model (.CLOCK(CLOCK), .PWM_OUT(PWM_OUT),
        .hi_len(hi_len), .lo_len(lo_len));
    always #5 CLOCK = ~CLOCK;
    always @(negedge CLOCK) begin
        tdiv = (tdiv == 9) ? 0 : tdiv + 1;
        TICK = (tdiv == 0);
    end
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge CLOCK);
        ADDR = a;
        WR_DATA = d;
        WR_EN = 1'b1;
        @(negedge CLOCK);
        WR_EN = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(negedge CLOCK);
        ADDR = a;
        RD_EN = 1'b1;
        @(negedge CLOCK);
        RD_EN = 1'b0;
        @(negedge CLOCK);
        chk(RD_DATA, e);
    endtask
    task automatic span(input logic [15:0] e, input int n);
        repeat (n) @(negedge CLOCK);
        chk(hi_len - lo_len, e);
    endtask
    initial begin
        repeat (6) @(negedge CLOCK);
        RESET_N = 1'b1;
        chk(16'({PWM_OUT, CLOCK_REQUEST}), 16'h0);
        rd(4'h0, 16'h0000);
        rd(4'h4, 16'hffff);
        wr(4'h8, 16'hff80);
        rd(4'h8, 16'h0000);
        rd(4'hc, 16'h0000);
        wr(4'h0, 16'h0003);
        wr(4'h4, 16'h0005);
        rd(4'h4, 16'h0005);
        wr(4'h8, 16'h0001);
        span(16'hfffe, 60);
        wr(4'h0, 16'h0009);
        rd(4'h0, 16'h0003);
        wr(4'h8, 16'h0009);
        span(16'hfffc, 60);
        wr(4'h4, 16'h0000);
        repeat (60) @(negedge CLOCK);
        chk(16'(PWM_OUT), 16'h1);
        rd(4'h0, 16'h0009);
        wr(4'h0, 16'h0000);
        wr(4'h4, 16'h0005);
        rd(4'h4, 16'h0005);
        repeat (60) @(negedge CLOCK);
        chk(16'(PWM_OUT), 16'h0);
        wr(4'h8, 16'h0005);
        repeat (4) @(negedge CLOCK);
        chk(16'(PWM_OUT), 16'h1);
        wr(4'h8, 16'h0004);
        repeat (4) @(negedge CLOCK);
        chk(16'({PWM_OUT, CLOCK_REQUEST}), 16'h2);
        wr(4'h0, 16'h0003);
        wr(4'h4, 16'h0005);
        wr(4'h8, 16'h0007);
        span(16'h0014, 250);
        wr(4'h8, 16'h0003);
        span(16'hffec, 250);
        SLEEP = 1'b1;
        repeat (5) @(negedge CLOCK);
        chk(16'({PWM_OUT, CLOCK_REQUEST}), 16'h0);
        SLEEP = 1'b0;
        CLK_EN = 1'b0;
        repeat (3) @(negedge CLOCK);
        CLK_EN = 1'b1;
        chk(16'(CLOCK_REQUEST), 16'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
